// file: bench/flash_dev_model.sv
// behavioural x16 nor flash: unlock decoding, boot guard, id and query modes
// assumes host pins are stable around every strobe edge
module flash_dev_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00C5, // arbitrary value
    parameter logic [15:0] DEV_CODE   = 16'h7A31, // arbitrary value
    parameter logic [15:0] UID_WORD   = 16'h5E10  // arbitrary value
) (
    input  wire logic        flash_ce_b, flash_oe_b, flash_we_b, flash_wp_b, flash_rst_b,
    input  wire logic [21:0] flash_addr,
    input  wire logic [15:0] flash_dq_out,
    output logic      [15:0] flash_dq_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [logic [21:0]];
    logic [15:0] rd   = 16'hFFFF;
    logic [3:0]  step = 4'h0;
    logic [3:0]  busy = 4'h0;
    logic [3:0]  s;
    logic [1:0]  mode = 2'h0;
    logic        tog  = 1'b0;
    realtime     t_we_fall = 0.0;
    wire  [21:0] a    = flash_addr;
    wire  [7:0]  d    = flash_dq_out[7:0];
    wire         boot = a < 22'h008000 && !flash_wp_b;
    // released bus shows the inverse, not the stale word
    assign flash_dq_in = (!flash_ce_b && !flash_oe_b) ? rd : ~rd;
    always @(negedge flash_we_b) t_we_fall = $realtime;
    always @(negedge flash_rst_b) begin
        step = 4'h0;
        mode = 2'h0;
        busy = 4'h0;
    end
    always @(negedge flash_oe_b) if (!flash_ce_b) begin
        if (busy != 4'h0) begin
            busy--;
            tog = !tog;
            rd = {9'h1FF, tog, 6'h3F};
        end else case (mode)
            2'h1: rd = a == 22'h0 ? MAKER_CODE : a == 22'h1 ? DEV_CODE : 16'h0000;
            2'h2: rd = 16'h0051;
            2'h3: rd = a < 22'h000008 ? UID_WORD ^ 16'(a) : 16'hFFFF;
            default: rd = mem.exists(a) ? mem[a] : 16'hFFFF;
        endcase
    end
    // strobes shorter than 5 ns are glitches and start nothing
    always @(posedge flash_we_b) if (!flash_ce_b && flash_oe_b && busy == 4'h0 &&
                                     $realtime - t_we_fall >= 5.0) begin
        s = step;
        step = 4'h0; // any bad cycle drops the sequence
        case (s)
            4'h0: if (a == 22'h555 && d == 8'hAA) step = 4'h1;
                else if (a == 22'h55 && d == 8'h98) mode = 2'h2;
                else if (a == 22'h0 && (d == 8'hF0 || d == 8'h00)) mode = 2'h0;
            4'h1: if (a == 22'h2AA && d == 8'h55) step = 4'h2;
            4'h2: if (a == 22'h555) case (d)
                8'hA0: step = 4'h3;
                8'h80: step = 4'h4;
                8'h90: mode = 2'h1;
                8'h98: mode = 2'h2;
                8'h88: mode = 2'h3;
                8'h85: step = 4'h7;
                default: step = 4'h0;
            endcase
            4'h3: begin
                if (!boot) mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & flash_dq_out;
                busy = 4'h4;
            end
            4'h4: if (a == 22'h555 && d == 8'hAA) step = 4'h5;
            4'h5: if (a == 22'h2AA && d == 8'h55) step = 4'h6;
            4'h6: begin
                if (d == 8'h50 && !boot)
                    foreach (mem[k]) if (k[21:12] == a[21:12]) mem[k] = 16'hFFFF;
                if (d == 8'h10 && flash_wp_b) mem.delete();
                busy = 4'h4;
            end
            4'h7: busy = 4'h4; // lock-out; no erase path exists
            default: step = 4'h0;
        endcase
    end
endmodule : flash_dev_model

// file: bench/flash_host_ctrl_tb.sv
// self-checking bench for flash_host_ctrl against a behavioural flash
// assumes one response per command, in command order
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module flash_host_ctrl_tb import flash_host_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] MAKER = 16'h00C5; // arbitrary value
    localparam logic [15:0] DEVC  = 16'h7A31; // arbitrary value
    localparam logic [15:0] UID   = 16'h5E10; // arbitrary value
    logic        clock = 0, rst_b = 0, cmd_valid = 0, boot_protect = 1;
    logic        cmd_ready, rsp_valid, flash_ce_b, flash_oe_b, flash_we_b;
    logic        flash_dq_oe, flash_wp_b, flash_rst_b;
    op_t         cmd_op = OP_READ;
    logic [21:0] cmd_addr = 0, flash_addr, pa;
    logic [15:0] cmd_wdata = 0, rsp_rdata, flash_dq_in, flash_dq_out, pd;
    logic [16:0] notes [$];
    int          n_mismatch = 0, compares = 0;
    always #12.5 clock = ~clock;
    flash_host_ctrl i_dut (.*);
    flash_dev_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEVC), .UID_WORD(UID)) i_flash (.*);
    task automatic cmd(op_t op, logic [21:0] a = 0, logic c = 0, logic [15:0] e = 0,
                       logic [15:0] d = 0);
        @(posedge clock) #1;
        cmd_op = op;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1;
        while (!cmd_ready) @(posedge clock) #1;
        @(posedge clock);
        notes.push_back({c, e});
        #1 cmd_valid = 0;
    endtask : cmd
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    always @(posedge clock) if (rsp_valid === 1'b1 && notes.size() != 0) begin
        if (notes[0][16]) `CHK(rsp_rdata, notes[0][15:0])
        void'(notes.pop_front());
    end
    initial begin
        #(25 * 20000);
        n_mismatch++;
        close_out();
    end
    initial begin
        void'($urandom(32'hF91AC44E));
        pa = {2'b01, 20'($urandom)}; // clear of the boot block
        pd = 16'($urandom);
        repeat (8) @(posedge clock);
        #1 rst_b = 1;
        cmd(OP_READ, pa, 1, 16'hFFFF);
        cmd(OP_PROGRAM, pa, 1, pd, pd);
        cmd(OP_READ, pa, 1, pd);
        cmd(OP_PROGRAM, 22'h7FFF, 1, 16'hFFFF, 16'h1234);
        cmd(OP_READ, 22'h7FFF, 1, 16'hFFFF);
        boot_protect = 0;
        cmd(OP_PROGRAM, 22'h7FFF, 1, 16'h1234, 16'h1234);
        cmd(OP_ID_ENTER);
        cmd(OP_READ, 22'h0, 1, MAKER);
        cmd(OP_READ, 22'h1, 1, DEVC);
        cmd(OP_MODE_EXIT);
        cmd(OP_QRY_STD);
        cmd(OP_READ, 22'h10, 1, 16'h0051);
        cmd(OP_MODE_EXIT);
        cmd(OP_READ, pa, 1, pd);
        cmd(OP_QRY_VENDOR);
        cmd(OP_READ, 22'h10, 1, 16'h0051);
        cmd(OP_MODE_EXIT);
        cmd(OP_SEC_ENTER);
        cmd(OP_READ, 22'h3, 1, UID ^ 16'h0003);
        cmd(OP_SEC_LOCK);
        cmd(OP_SEC_EXIT);
        cmd(OP_READ, pa, 1, pd);
        cmd(OP_ID_ENTER);
        cmd(OP_HW_RESET);
        cmd(OP_READ, 22'h0, 1, 16'hFFFF);
        cmd(OP_SECT_ERASE, pa);
        cmd(OP_READ, pa, 1, 16'hFFFF);
        boot_protect = 1;
        cmd(OP_CHIP_ERASE);
        cmd(OP_READ, 22'h7FFF, 1, 16'h1234);
        boot_protect = 0;
        cmd(OP_CHIP_ERASE);
        cmd(OP_READ, 22'h7FFF, 1, 16'hFFFF);
        repeat (4) @(posedge clock);
        close_out();
    end
endmodule : flash_host_ctrl_tb

// file: src/bus_cycle_if.sv
// one flash bus cycle request between sequencer and pin engine
// assumes a single clock shared by both ends
interface bus_cycle_if;
    import flash_host_pkg::*;
    logic              req;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport master (output req, output wr, output addr, output wdata,
                    input done, input rdata);
    modport slave  (input req, input wr, input addr, input wdata,
                    output done, output rdata);
endinterface : bus_cycle_if

// file: src/flash_cycle_engine.sv
// pin engine: turns one cycle request into a timed ce/oe/we waveform
// assumes requests only arrive while idle (sequencer waits for done)
module flash_cycle_engine
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // request side
    bus_cycle_if.slave             cyc,
    // flash pins
    output logic                   ce_b,
    output logic                   oe_b,
    output logic                   we_b,
    output logic [ADDR_W-1:0]      addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe
);
    typedef enum logic [1:0] {
        ENG_IDLE   = 2'b00,
        ENG_SETUP  = 2'b01,
        ENG_STROBE = 2'b10,
        ENG_HOLD   = 2'b11
    } eng_state_t;

    eng_state_t        state_ff, nxt_state;
    logic [2:0]        cnt_ff, nxt_cnt;
    logic              wr_ff, nxt_wr;
    logic              ce_b_ff, nxt_ce_b, oe_b_ff, nxt_oe_b, we_b_ff, nxt_we_b;
    logic              dq_oe_ff, nxt_dq_oe, done_ff, nxt_done;
    logic [ADDR_W-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] dq_out_ff, nxt_dq_out, rdata_ff, nxt_rdata;

    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_wr     = wr_ff;
        nxt_ce_b   = ce_b_ff;
        nxt_oe_b   = oe_b_ff;
        nxt_we_b   = we_b_ff;
        nxt_dq_oe  = dq_oe_ff;
        nxt_addr   = addr_ff;
        nxt_dq_out = dq_out_ff;
        nxt_rdata  = rdata_ff;
        nxt_done   = 1'b0;
        unique case (state_ff)
            ENG_IDLE: begin
                if (cyc.req) begin
                    nxt_wr     = cyc.wr;
                    nxt_addr   = cyc.addr;
                    nxt_dq_out = cyc.wdata;
                    nxt_ce_b   = 1'b0;
                    nxt_dq_oe  = cyc.wr;
                    nxt_state  = ENG_SETUP;
                end
            end
            ENG_SETUP: begin
                // oe stays high through a write so the strobe is never inhibited
                if (wr_ff) begin
                    nxt_we_b = 1'b0;
                    nxt_cnt  = WE_CYC - 3'd1;
                end else begin
                    nxt_oe_b = 1'b0;
                    nxt_cnt  = RC_CYC - 3'd1;
                end
                nxt_state = ENG_STROBE;
            end
            ENG_STROBE: begin
                if (cnt_ff == 3'd0) begin
                    nxt_we_b = 1'b1;
                    nxt_oe_b = 1'b1;
                    if (!wr_ff) begin
                        nxt_rdata = dq_in;
                    end
                    nxt_state = ENG_HOLD;
                end else begin
                    nxt_cnt = cnt_ff - 3'd1;
                end
            end
            ENG_HOLD: begin
                // data held one cycle past the rising strobe edge
                nxt_ce_b  = 1'b1;
                nxt_dq_oe = 1'b0;
                nxt_done  = 1'b1;
                nxt_state = ENG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_ff  <= ENG_IDLE;
            cnt_ff    <= 3'h0;
            wr_ff     <= 1'b0;
            ce_b_ff   <= 1'b1;
            oe_b_ff   <= 1'b1;
            we_b_ff   <= 1'b1;
            dq_oe_ff  <= 1'b0;
            done_ff   <= 1'b0;
            addr_ff   <= '0;
            dq_out_ff <= 16'h0000;
            rdata_ff  <= 16'h0000;
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            wr_ff     <= nxt_wr;
            ce_b_ff   <= nxt_ce_b;
            oe_b_ff   <= nxt_oe_b;
            we_b_ff   <= nxt_we_b;
            dq_oe_ff  <= nxt_dq_oe;
            done_ff   <= nxt_done;
            addr_ff   <= nxt_addr;
            dq_out_ff <= nxt_dq_out;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign ce_b      = ce_b_ff;
    assign oe_b      = oe_b_ff;
    assign we_b      = we_b_ff;
    assign addr      = addr_ff;
    assign dq_out    = dq_out_ff;
    assign dq_oe     = dq_oe_ff;
    assign cyc.done  = done_ff;
    assign cyc.rdata = rdata_ff;

    sequence s_we_low;
        !we_b ##1 !we_b;
    endsequence
    sequence s_oe_low;
        !oe_b ##1 !oe_b ##1 !oe_b ##1 !oe_b;
    endsequence

    property p_we_width;
        @(posedge clock) disable iff (!rst_b) $fell(we_b) |-> s_we_low ##1 we_b;
    endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

    property p_we_not_inhibited;
        @(posedge clock) disable iff (!rst_b) !we_b |-> (oe_b && !ce_b);
    endproperty
    a_we_not_inhibited: assert property (p_we_not_inhibited) else $error("write inhibited");

    property p_read_len;
        @(posedge clock) disable iff (!rst_b) $fell(oe_b) |-> s_oe_low ##1 oe_b;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read cycle length wrong");

    property p_dq_driven;
        @(posedge clock) disable iff (!rst_b) (!we_b || $rose(we_b)) |-> dq_oe;
    endproperty
    a_dq_driven: assert property (p_dq_driven) else $error("data bus floating in write");
endmodule : flash_cycle_engine

// file: src/flash_host_ctrl.sv
// host-side controller for a parallel x16 nor flash: command sequences,
// mode entry/exit, hardware reset and toggle-bit completion polling
// assumes flash inputs are synchronous to clock and the flash is the only load
module flash_host_ctrl
    import flash_host_pkg::*;
(
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    // user command port
    input  wire logic                  cmd_valid,
    output logic                       cmd_ready,
    input  wire flash_host_pkg::op_t   cmd_op,
    input  wire logic [ADDR_W-1:0]     cmd_addr,
    input  wire logic [DATA_W-1:0]     cmd_wdata,
    output logic                       rsp_valid,
    output logic [DATA_W-1:0]          rsp_rdata,
    input  wire logic                  boot_protect,
    // flash pins
    output logic                       flash_ce_b,
    output logic                       flash_oe_b,
    output logic                       flash_we_b,
    output logic [ADDR_W-1:0]          flash_addr,
    input  wire logic [DATA_W-1:0]     flash_dq_in,
    output logic [DATA_W-1:0]          flash_dq_out,
    output logic                       flash_dq_oe,
    output logic                       flash_wp_b,
    output logic                       flash_rst_b
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        M_IDLE      = 3'b000,
        M_RST_LO    = 3'b001,
        M_RST_REC   = 3'b010,
        M_ISSUE     = 3'b011,
        M_WAIT      = 3'b100,
        M_POLL      = 3'b101,
        M_POLL_WAIT = 3'b110
    } main_state_t;

    bus_cycle_if cyc ();

    main_state_t       st_ff, nxt_st;
    op_t               op_ff, nxt_op;
    logic [ADDR_W-1:0] uaddr_ff, nxt_uaddr;
    logic [DATA_W-1:0] udata_ff, nxt_udata, rdata_ff, nxt_rdata;
    logic [2:0]        step_ff, nxt_step;
    logic [11:0]       cnt_ff, nxt_cnt;
    logic              prev_tog_ff, nxt_prev_tog, have_prev_ff, nxt_have_prev;
    logic              rsp_ff, nxt_rsp, frst_ff, nxt_frst, wp_ff;

    // cycles in each command; data read counts as one cycle
    function automatic logic [2:0] seq_len(input op_t op);
        unique case (op)
            OP_READ, OP_QRY_STD, OP_MODE_EXIT:      seq_len = 3'd1;
            OP_QRY_VENDOR, OP_ID_ENTER, OP_SEC_ENTER: seq_len = 3'd3;
            OP_PROGRAM, OP_SEC_EXIT, OP_SEC_LOCK:   seq_len = 3'd4;
            OP_SECT_ERASE, OP_CHIP_ERASE:           seq_len = 3'd6;
            default:                                seq_len = 3'd1;
        endcase
    endfunction : seq_len

    // address and data for one step; unlock prefix is shared by every command except read, standard query and mode exit
    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_t op, input logic [2:0] s,
                                                        input logic [ADDR_W-1:0] a,
                                                        input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] c;
        logic              is_erase;
        c        = CMD_ZERO;
        // only erases repeat the unlock pair; four-cycle commands carry their tail at step 3
        is_erase = (op == OP_SECT_ERASE) || (op == OP_CHIP_ERASE);
        unique case (op)
            OP_QRY_VENDOR: c = CMD_QUERY;
            OP_ID_ENTER:   c = CMD_ID_ENTER;
            OP_SEC_ENTER:  c = CMD_SEC_ENTER;
            OP_SEC_EXIT:   c = CMD_ID_ENTER;
            OP_SEC_LOCK:   c = CMD_SEC_LOCK;
            OP_PROGRAM:    c = CMD_PROGRAM;
            default:       c = CMD_ERASE;
        endcase
        if (op == OP_READ)
            seq_word = {a, d};
        else if (op == OP_QRY_STD)
            seq_word = {ADDR_QRY_STD, CMD_QUERY};
        else if (op == OP_MODE_EXIT)
            seq_word = {ADDR_ZERO, CMD_EXIT};
        else if (s == 3'd0 || (s == 3'd3 && is_erase))
            seq_word = {ADDR_UNLOCK1, CMD_UNLOCK1};
        else if (s == 3'd1 || s == 3'd4)
            seq_word = {ADDR_UNLOCK2, CMD_UNLOCK2};
        else if (s == 3'd2)
            seq_word = {ADDR_UNLOCK1, c};
        else if (op == OP_PROGRAM)
            seq_word = {a, d};
        else if (op == OP_SECT_ERASE)
            seq_word = {a, CMD_SECT_ER};
        else if (op == OP_CHIP_ERASE)
            seq_word = {ADDR_UNLOCK1, CMD_CHIP_ER};
        else
            seq_word = {ADDR_ZERO, CMD_ZERO};
    endfunction : seq_word

    // operations that start an internal write and must be polled
    function automatic logic needs_poll(input op_t op);
        needs_poll = (op == OP_PROGRAM) || (op == OP_SECT_ERASE) ||
                     (op == OP_CHIP_ERASE) || (op == OP_SEC_LOCK);
    endfunction : needs_poll

    logic [ADDR_W+DATA_W-1:0] word;
    assign word      = seq_word(op_ff, step_ff, uaddr_ff, udata_ff);
    assign cyc.req   = (st_ff == M_ISSUE) || (st_ff == M_POLL);
    assign cyc.wr    = (st_ff == M_ISSUE) && (op_ff != OP_READ);
    assign cyc.addr  = (st_ff == M_POLL) ? uaddr_ff : word[ADDR_W+DATA_W-1:DATA_W];
    assign cyc.wdata = word[DATA_W-1:0];
    assign cmd_ready = (st_ff == M_IDLE);

    always_comb begin
        nxt_st        = st_ff;
        nxt_op        = op_ff;
        nxt_uaddr     = uaddr_ff;
        nxt_udata     = udata_ff;
        nxt_rdata     = rdata_ff;
        nxt_step      = step_ff;
        nxt_cnt       = cnt_ff;
        nxt_prev_tog  = prev_tog_ff;
        nxt_have_prev = have_prev_ff;
        nxt_frst      = frst_ff;
        nxt_rsp       = 1'b0;
        unique case (st_ff)
            M_IDLE: begin
                if (cmd_valid) begin
                    nxt_op    = cmd_op;
                    nxt_uaddr = cmd_addr;
                    nxt_udata = cmd_wdata;
                    nxt_step  = 3'd0;
                    nxt_cnt   = 12'h000;
                    if (cmd_op == OP_HW_RESET) begin
                        nxt_frst = 1'b0;
                        nxt_st   = M_RST_LO;
                    end else begin
                        nxt_st = M_ISSUE;
                    end
                end
            end
            M_RST_LO: begin
                if (cnt_ff == RP_CYC - 12'd1) begin
                    nxt_frst = 1'b1;
                    nxt_cnt  = 12'h000;
                    nxt_st   = M_RST_REC;
                end else begin
                    nxt_cnt = cnt_ff + 12'd1;
                end
            end
            M_RST_REC: begin
                // no bus activity until the part has recovered
                if (cnt_ff == RHR_CYC - 12'd1) begin
                    nxt_rsp = (op_ff == OP_HW_RESET);
                    nxt_st  = M_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + 12'd1;
                end
            end
            M_ISSUE: nxt_st = M_WAIT;
            M_WAIT: begin
                if (cyc.done) begin
                    if (step_ff == seq_len(op_ff) - 3'd1) begin
                        nxt_rdata = cyc.rdata;
                        if (needs_poll(op_ff)) begin
                            nxt_have_prev = 1'b0;
                            nxt_st        = M_POLL;
                        end else begin
                            nxt_rsp = 1'b1;
                            nxt_st  = M_IDLE;
                        end
                    end else begin
                        nxt_step = step_ff + 3'd1;
                        nxt_st   = M_ISSUE;
                    end
                end
            end
            M_POLL: nxt_st = M_POLL_WAIT;
            M_POLL_WAIT: begin
                // complement-poll bit is unreliable in the security space,
                // so completion is two equal toggle bits for every operation
                if (cyc.done) begin
                    nxt_rdata = cyc.rdata;
                    if (have_prev_ff && prev_tog_ff == cyc.rdata[TOGGLE_BIT]) begin
                        nxt_rsp = 1'b1;
                        nxt_st  = M_IDLE;
                    end else begin
                        nxt_prev_tog  = cyc.rdata[TOGGLE_BIT];
                        nxt_have_prev = 1'b1;
                        nxt_st        = M_POLL;
                    end
                end
            end
            default: nxt_st = M_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_ff        <= M_RST_LO;
            op_ff        <= OP_READ;
            uaddr_ff     <= '0;
            udata_ff     <= 16'h0000;
            rdata_ff     <= 16'h0000;
            step_ff      <= 3'h0;
            cnt_ff       <= 12'h000;
            prev_tog_ff  <= 1'b0;
            have_prev_ff <= 1'b0;
            rsp_ff       <= 1'b0;
            frst_ff      <= 1'b0;
            wp_ff        <= 1'b0;
        end else begin
            st_ff        <= nxt_st;
            op_ff        <= nxt_op;
            uaddr_ff     <= nxt_uaddr;
            udata_ff     <= nxt_udata;
            rdata_ff     <= nxt_rdata;
            step_ff      <= nxt_step;
            cnt_ff       <= nxt_cnt;
            prev_tog_ff  <= nxt_prev_tog;
            have_prev_ff <= nxt_have_prev;
            rsp_ff       <= nxt_rsp;
            frst_ff      <= nxt_frst;
            wp_ff        <= !boot_protect;
        end
    end

    assign rsp_valid   = rsp_ff;
    assign rsp_rdata   = rdata_ff;
    assign flash_rst_b = frst_ff;
    assign flash_wp_b  = wp_ff;

    flash_cycle_engine u_engine (
        .clock  (clock),
        .rst_b  (rst_b),
        .cyc    (cyc.slave),
        .ce_b   (flash_ce_b),
        .oe_b   (flash_oe_b),
        .we_b   (flash_we_b),
        .addr   (flash_addr),
        .dq_in  (flash_dq_in),
        .dq_out (flash_dq_out),
        .dq_oe  (flash_dq_oe)
    );

    property p_rst_pulse;
        @(posedge clock) disable iff (!rst_b) $fell(flash_rst_b) |-> !flash_rst_b[*8];
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");

    property p_rst_recovery;
        @(posedge clock) disable iff (!rst_b) $rose(flash_rst_b) |-> flash_ce_b[*8];
    endproperty
    a_rst_recovery: assert property (p_rst_recovery) else $error("access during recovery");

    property p_sec_entry;
        @(posedge clock) disable iff (!rst_b)
            (st_ff == M_ISSUE && op_ff == OP_SEC_ENTER && step_ff == 3'd2) |->
            (cyc.addr == ADDR_UNLOCK1 && cyc.wdata == CMD_SEC_ENTER);
    endproperty
    a_sec_entry: assert property (p_sec_entry) else $error("bad security entry cycle");

    property p_wp_follows;
        @(posedge clock) disable iff (!rst_b) boot_protect |=> !flash_wp_b;
    endproperty
    a_wp_follows: assert property (p_wp_follows) else $error("write protect not driven");
endmodule : flash_host_ctrl

// file: src/flash_host_pkg.sv
// constants for the parallel x16 nor flash host controller
// assumes a 40 MHz clock; all pin timing is counted in cycles of it
package flash_host_pkg;
    localparam int          CLK_MHZ      = 40;
    localparam int          ADDR_W       = 22;
    localparam int          DATA_W       = 16;
    // pin timing, figures in ns, cycle counts derived (least times round up)
    localparam int          WE_LOW_NS    = 40;
    localparam int          GLITCH_NS    = 5;
    localparam int          READ_CYC_NS  = 90;
    localparam int          RST_PULSE_NS = 500;
    localparam int          RST_REC_NS   = 50000;
    localparam logic [2:0]  WE_CYC       = 3'((WE_LOW_NS * CLK_MHZ + 999) / 1000);
    localparam logic [2:0]  RC_CYC       = 3'((READ_CYC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] RP_CYC       = 12'((RST_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [11:0] RHR_CYC      = 12'((RST_REC_NS * CLK_MHZ + 999) / 1000);
    // command addresses and codes (low byte only, upper byte driven to zero)
    localparam logic [21:0] ADDR_UNLOCK1 = 22'h000555;
    localparam logic [21:0] ADDR_UNLOCK2 = 22'h0002AA;
    localparam logic [21:0] ADDR_QRY_STD = 22'h000055;
    localparam logic [21:0] ADDR_ZERO    = 22'h000000;
    localparam logic [15:0] CMD_UNLOCK1  = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2  = 16'h0055;
    localparam logic [15:0] CMD_PROGRAM  = 16'h00A0;
    localparam logic [15:0] CMD_ERASE    = 16'h0080;
    localparam logic [15:0] CMD_SECT_ER  = 16'h0050;
    localparam logic [15:0] CMD_CHIP_ER  = 16'h0010;
    localparam logic [15:0] CMD_QUERY    = 16'h0098;
    localparam logic [15:0] CMD_ID_ENTER = 16'h0090;
    localparam logic [15:0] CMD_EXIT     = 16'h00F0;
    localparam logic [15:0] CMD_SEC_ENTER= 16'h0088;
    localparam logic [15:0] CMD_SEC_LOCK = 16'h0085;
    localparam logic [15:0] CMD_ZERO     = 16'h0000;
    localparam int          TOGGLE_BIT   = 6;

    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_PROGRAM    = 4'h1,
        OP_SECT_ERASE = 4'h2,
        OP_CHIP_ERASE = 4'h3,
        OP_QRY_STD    = 4'h4,
        OP_QRY_VENDOR = 4'h5,
        OP_MODE_EXIT  = 4'h6,
        OP_ID_ENTER   = 4'h7,
        OP_SEC_ENTER  = 4'h8,
        OP_SEC_EXIT   = 4'h9,
        OP_SEC_LOCK   = 4'hA,
        OP_HW_RESET   = 4'hB
    } op_t;
endpackage : flash_host_pkg
